/* dv/front_panel_ctrl_checker.sv */
// Purpose: Port-level assertions for the front-panel port control.
// Assumes: One mclk domain, srst synchronous and active high.
// Notes:   CTRL bits are shadowed from completed APB writes.
`timescale 1ns/1ps
module front_panel_ctrl_checker #(
  parameter logic [31:0] ONE_HOLD_CYCLES = panel_pkg::ONE_HOLD_CYC,
  parameter logic [31:0] BLINK_CYCLES    = panel_pkg::BLINK_CYC
)(
  // Clock, reset and APB
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Panel side
  input wire logic        btn_ok_n,
  input wire logic [7:0]  relay,
  input wire logic [7:0]  led_on,
  input wire logic [7:0]  led_off,
  input wire logic        status_red,
  input wire logic        status_green
);
  logic        wr_done;
  logic [5:0]  ctrl_q;
  logic [7:0]  msk_q;
  logic [1:0]  st_q;
  logic [31:0] ok_cnt;
  logic [31:0] stay;

  assign wr_done = psel && penable && pready && pwrite;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= 6'h00;
      msk_q  <= 8'h00;
      ok_cnt <= 32'h0;
      stay   <= 32'h0;
    end else begin
      if (wr_done && paddr == panel_pkg::CTRL_OFS)
        ctrl_q <= pwdata[5:0];
      if (wr_done && paddr == panel_pkg::RESET_CMD_OFS)
        msk_q <= pwdata[7:0];
      // Raw pin time, so a hold cut short is never credited
      ok_cnt <= btn_ok_n ? 32'h0 : ok_cnt + 32'h1;
      stay <= (!ctrl_q[4] || st_q != {status_red, status_green})
              ? 32'h0 : stay + 32'h1;
    end
    st_q <= {status_red, status_green};
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_no_link;
    (!ctrl_q[2] && !ctrl_q[4]) [*3] |-> status_red && !status_green;
  endproperty
  a_no_link: assert property (p_no_link)
    else $error("status not red without link");
  property p_wait_addr;
    (ctrl_q[4:2] == 3'b001) [*3] |-> status_red && status_green;
  endproperty
  a_wait_addr: assert property (p_wait_addr)
    else $error("status not orange while address pends");
  property p_online;
    (ctrl_q[4:2] == 3'b011) [*3] |-> !status_red && status_green;
  endproperty
  a_online: assert property (p_online)
    else $error("status not green when online");
  property p_boot_blink;
    stay <= BLINK_CYCLES + 32'h3;
  endproperty
  a_boot_blink: assert property (p_boot_blink)
    else $error("status steady in boot mode");
  property p_ctrl_relay;
    wr_done && paddr == panel_pkg::CTRL_OFS |=> $stable(relay) [*3];
  endproperty
  a_ctrl_relay: assert property (p_ctrl_relay)
    else $error("relay moved on control write");
  property p_reset_off;
    wr_done && paddr == panel_pkg::RESET_CMD_OFS
      && (pwdata[7:0] & relay) != 8'h00 |=> (relay & msk_q) == 8'h00;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("reset command left port on");
  property p_led_excl;
    (led_on & led_off) == 8'h00;
  endproperty
  a_led_excl: assert property (p_led_excl)
    else $error("green and red lit on one port");
  property p_hold;
    $changed(relay) && ok_cnt != 32'h0 |-> ok_cnt >= ONE_HOLD_CYCLES;
  endproperty
  a_hold: assert property (p_hold)
    else $error("relay switched before full hold");
  property p_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("pready not a single cycle after setup");
  property p_unmapped;
    psel && !penable && paddr >= 8'h20 |=> pready && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  c_boot: cover property (ctrl_q[4] && stay == 32'h0);
  c_all_on: cover property (relay == 8'hFF);
  c_refused: cover property (pready && pslverr);
endmodule

bind front_panel_ctrl front_panel_ctrl_checker #(
  .ONE_HOLD_CYCLES(ONE_HOLD_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)
) u_front_panel_ctrl_checker (
  .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .btn_ok_n(btn_ok_n),
  .relay(relay), .led_on(led_on), .led_off(led_off),
  .status_red(status_red), .status_green(status_green)
);

/* dv/front_panel_port_switch_control_test.sv */
// Purpose: Self-checking bench for the front-panel port control.
// Assumes: Shortened second, blink, hold and debounce counts.
// Notes:   Register rows first, then status, panel and timer cases.
`timescale 1ns/1ps
module front_panel_port_switch_control_test;
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } row_t;
  row_t rows [16] = '{
    '{8'h10, 1'b0, 32'h0, 32'h0A, 1'b0}, '{8'h18, 1'b0, 32'h0, 32'h0A, 1'b0},
    '{8'h00, 1'b0, 32'h0, 32'h00, 1'b0}, '{8'h1C, 1'b0, 32'h0, 32'h00, 1'b0},
    '{8'h04, 1'b0, 32'h0, 32'h00, 1'b0}, '{8'h10, 1'b1, 32'h2, 32'h00, 1'b0},
    '{8'h10, 1'b0, 32'h0, 32'h02, 1'b0}, '{8'h20, 1'b1, 32'hFF, 32'h0, 1'b1},
    '{8'h20, 1'b0, 32'h0, 32'h00, 1'b1}, '{8'h1C, 1'b1, 32'h30, 32'h0, 1'b0},
    '{8'h1C, 1'b0, 32'h0, 32'h00, 1'b0}, '{8'h04, 1'b1, 32'h3, 32'h00, 1'b0},
    '{8'h08, 1'b0, 32'h0, 32'h03, 1'b0}, '{8'h08, 1'b1, 32'h1, 32'h00, 1'b0},
    '{8'h04, 1'b0, 32'h0, 32'h02, 1'b0}, '{8'h04, 1'b1, 32'h1, 32'h00, 1'b0}};
  logic [31:0] st_in [3] = '{32'h0, 32'h4, 32'hC};
  logic [31:0] st_ex [3] = '{32'h2, 32'h3, 32'h1};
  logic        mclk    = 1'b0;
  logic        srst    = 1'b1;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        btn_select_n;
  logic        btn_ok_n;
  logic [7:0]  relay;
  logic [7:0]  led_on;
  logic [7:0]  led_off;
  logic        status_red;
  logic        status_green;
  logic [1:0]  stat;
  logic [1:0]  sn;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          n_checks = 0;

  assign stat = {status_red, status_green};
  always #2.5 mclk = ~mclk;

  front_panel_ctrl #(
    .SECOND_CYCLES(32'h28), .BLINK_CYCLES(32'h8), .ALL_HOLD_CYCLES(32'h19),
    .ONE_HOLD_CYCLES(32'hA), .DEBOUNCE_CYCLES(32'h4)
  ) u_front_panel_ctrl (
    .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .btn_select_n(btn_select_n), .btn_ok_n(btn_ok_n), .relay(relay),
    .led_on(led_on), .led_off(led_off), .status_red(status_red),
    .status_green(status_green)
  );
  panel_operator u_panel_operator (
    .mclk(mclk), .btn_select_n(btn_select_n), .btn_ok_n(btn_ok_n)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, x);
    apb(a, 1'b0, 32'h0);
    check(rd & m, x);
  endtask
  task automatic rly(input logic [7:0] e);
    @(negedge mclk);
    check({24'h0, relay}, {24'h0, e});
  endtask
  // Sees whether a light vector was both lit and dark
  task automatic blink(input int which, output logic [1:0] seen);
    logic [7:0] s;
    seen = 2'b00;
    repeat (24) begin
      @(negedge mclk);
      s = (which == 0) ? led_on : (which == 1) ? led_off : {6'h0, stat};
      if (s != 8'h00) seen[1] = 1'b1;
      else seen[0] = 1'b1;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #60000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    int t;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rly(8'h00);
    check({24'h0, led_off}, 32'hFF);
    check({30'h0, stat}, 32'h2);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      check({31'h0, err}, {31'h0, rows[i].e});
      if (!rows[i].w) check(rd, rows[i].x);
    end
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, st_in[k]);
      repeat (3) @(posedge mclk);
      check({30'h0, stat}, st_ex[k]);
    end
    wr(8'h00, 32'h1C);
    blink(2, sn);
    check({30'h0, sn}, 32'h3);
    wr(8'h00, 32'h0C);
    rly(8'h03);
    wr(8'h00, 32'h2C);
    rly(8'h03);
    u_panel_operator.push(1'b1, 12);
    rdm(8'h1C, 32'h30, 32'h10);
    blink(0, sn);
    check({30'h0, sn}, 32'h3);
    u_panel_operator.push(1'b0, 40);
    rly(8'hFF);
    u_panel_operator.push(1'b1, 12);
    rdm(8'h1C, 32'h30, 32'h20);
    blink(1, sn);
    check({30'h0, sn}, 32'h3);
    u_panel_operator.push(1'b0, 15);
    rly(8'hFF);
    u_panel_operator.push(1'b0, 40);
    rly(8'h00);
    u_panel_operator.push(1'b1, 12);
    rdm(8'h1C, 32'h37, 32'h30);
    u_panel_operator.push(1'b0, 25);
    rly(8'h01);
    blink(0, sn);
    check({30'h0, sn}, 32'h3);
    u_panel_operator.push(1'b1, 12);
    rdm(8'h1C, 32'h37, 32'h31);
    u_panel_operator.push(1'b0, 25);
    rly(8'h03);
    u_panel_operator.push(1'b0, 25);
    rly(8'h01);
    wr(8'h00, 32'h2F);
    rdm(8'h1C, 32'h30, 32'h00);
    check({24'h0, led_on}, 32'h01);
    check({24'h0, led_off}, 32'hFE);
    u_panel_operator.push(1'b1, 12);
    rdm(8'h1C, 32'h37, 32'h30);
    wr(8'h00, 32'h2D);
    u_panel_operator.push(1'b1, 12);
    rdm(8'h1C, 32'h30, 32'h20);
    wr(8'h00, 32'h2C);
    wr(8'h0C, 32'h05);
    rly(8'h00);
    rdm(8'h0C, 32'hFF, 32'h01);
    repeat (30) @(posedge mclk);
    rly(8'h00);
    for (t = 0; t < 120 && relay !== 8'h01; t++) @(posedge mclk);
    rly(8'h01);
    wr(8'h18, 32'h01);
    wr(8'h14, 32'h104);
    rly(8'h05);
    for (t = 0; t < 120 && relay !== 8'h01; t++) @(posedge mclk);
    rly(8'h01);
    wr(8'h14, 32'h201);
    rly(8'h00);
    for (t = 0; t < 120 && relay !== 8'h01; t++) @(posedge mclk);
    rly(8'h01);
    report_and_stop();
  end
endmodule

/* dv/panel_operator.sv */
// Purpose: Operator at the front panel pressing select and confirm.
// Assumes: Pins idle high through pull-ups; pressed reads low.
// Notes:   Each press starts with bounce shorter than the debounce
//          time, so only the steady part may count.
`timescale 1ns/1ps
module panel_operator (
  // Clock
  input  wire logic mclk,
  // Button pins
  output logic      btn_select_n,
  output logic      btn_ok_n
);
  initial begin
    btn_select_n = 1'b1;
    btn_ok_n     = 1'b1;
  end

  task automatic push(input logic sel, input int cycles);
    for (int i = 0; i < 6 + cycles; i++) begin
      @(posedge mclk);
      if (sel)
        btn_select_n <= (i < 6) ? i[0] : 1'b0;
      else
        btn_ok_n <= (i < 6) ? i[0] : 1'b0;
    end
    @(posedge mclk);
    btn_select_n <= 1'b1;
    btn_ok_n     <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask
endmodule

/* src/button_debounce.sv */
// Purpose: Synchronise and debounce the select and confirm buttons.
// Assumes: Button pins are active low and asynchronous to mclk.
// Notes:   A level change counts only after it stays stable for the
//          whole debounce time.
`timescale 1ns/1ps
module button_debounce #(
  parameter logic [31:0] DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYC
)(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Button pins
  input  wire logic btn_select_n,
  input  wire logic btn_ok_n,
  // Debounced events
  button_if.deb     btn
);

  typedef struct packed {
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [1:0]       stable;
    logic [1:0][31:0] cnt;
    logic             press;
  } deb_state_t;

  deb_state_t q;
  deb_state_t n;

  always_comb begin
    n = q;
    n.sync1 = {~btn_ok_n, ~btn_select_n};
    n.sync2 = q.sync1;
    n.press = 1'b0;
    for (int i = 0; i < 2; i++) begin
      // Bounce restarts the count, so one press gives one event
      if (q.sync2[i] == q.stable[i]) begin
        n.cnt[i] = '0;
      end else if (q.cnt[i] == DEBOUNCE_CYCLES - 32'h1) begin
        n.cnt[i]    = '0;
        n.stable[i] = q.sync2[i];
        if (i == 0 && q.sync2[i]) begin
          n.press = 1'b1;
        end
      end else begin
        n.cnt[i] = q.cnt[i] + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign btn.sel_press = q.press;
  assign btn.ok_held   = q.stable[1];

endmodule

/* src/button_if.sv */
// Purpose: Carries debounced button events to the panel core.
// Assumes: Both ends on mclk.
// Notes:   Press is a one-cycle pulse, held is a level.
`timescale 1ns/1ps
interface button_if;
  logic sel_press;
  logic ok_held;

  modport deb  (output sel_press, output ok_held);
  modport core (input  sel_press, input  ok_held);
endinterface

/* src/front_panel_ctrl.sv */
// Purpose: Front-panel control of relay ports, indicators and timers.
// Assumes: APB slave with no wait state; buttons active low.
// Notes:   Relays change only by srst (power-up), panel, software or port timers.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module front_panel_ctrl #(
  parameter logic [31:0] SECOND_CYCLES   = panel_pkg::SECOND_CYC,
  parameter logic [31:0] BLINK_CYCLES    = panel_pkg::BLINK_CYC,
  parameter logic [31:0] ALL_HOLD_CYCLES = panel_pkg::ALL_HOLD_CYC,
  parameter logic [31:0] ONE_HOLD_CYCLES = panel_pkg::ONE_HOLD_CYC,
  parameter logic [31:0] DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYC
)(
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              srst,
  // APB slave
  input  wire logic [7:0]                        paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Buttons
  input  wire logic                              btn_select_n,
  input  wire logic                              btn_ok_n,
  // Relays and indicators
  output logic      [panel_pkg::NUM_PORTS-1:0]   relay,
  output logic      [panel_pkg::NUM_PORTS-1:0]   led_on,
  output logic      [panel_pkg::NUM_PORTS-1:0]   led_off,
  output logic                                   status_red,
  output logic                                   status_green
);

  localparam int NP = panel_pkg::NUM_PORTS;
  localparam int TW = panel_pkg::TMR_W;
  localparam logic [panel_pkg::SEL_W-1:0] LAST_SEL = 3'(NP - 1);

  typedef struct packed {
    logic [NP-1:0]          relay;
    logic [NP-1:0]          led_on;
    logic [NP-1:0]          led_off;
    logic                   st_red;
    logic                   st_green;
    logic [NP-1:0]          rst_act;
    logic [NP-1:0]          bat_act;
    logic [NP-1:0]          bat_second;
    logic [NP-1:0][TW-1:0]  rst_rem;
    logic [NP-1:0][TW-1:0]  bat_rem;
    logic [TW-1:0]          rst_dur;
    logic [TW-1:0]          bat_time;
    logic                   skip_on;
    logic                   skip_off;
    logic                   link_up;
    logic                   ip_ok;
    logic                   boot;
    panel_pkg::panel_mode_t mode;
    logic [panel_pkg::SEL_W-1:0] sel;
    logic [31:0]            hold_cnt;
    logic                   hold_done;
    logic [31:0]            sec_cnt;
    logic [31:0]            blink_cnt;
    logic                   blink;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } panel_state_t;

  panel_state_t q;
  panel_state_t n;
  button_if     btn ();

  logic          sec_tick;
  logic          setup;
  logic          wr;
  logic          hit;
  logic [31:0]   hold_target;
  logic [NP-1:0] wmask;
  logic          base_red;
  logic          base_green;

  // A zero duration would never expire; it runs as one second
  function automatic logic [TW-1:0] at_least_one(input logic [TW-1:0] v);
    return (v == '0) ? 16'h0001 : v;
  endfunction

  // ----------------------------------------------------------------
  // Button conditioning
  // ----------------------------------------------------------------
  button_debounce #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .mclk         (mclk),
    .srst         (srst),
    .btn_select_n (btn_select_n),
    .btn_ok_n     (btn_ok_n),
    .btn          (btn.deb)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n           = q;
    sec_tick    = (q.sec_cnt == SECOND_CYCLES - 32'h1);
    setup       = psel & ~penable;
    wr          = psel & penable & q.pready & pwrite;
    wmask       = pwdata[NP-1:0];
    hold_target = (q.mode == panel_pkg::MODE_SINGLE) ?
                  ONE_HOLD_CYCLES : ALL_HOLD_CYCLES;
    hit         = 1'b1;

    // Dividers
    n.sec_cnt = sec_tick ? '0 : q.sec_cnt + 32'h1;
    if (q.blink_cnt == BLINK_CYCLES - 32'h1) begin
      n.blink_cnt = '0;
      n.blink     = ~q.blink;
    end else begin
      n.blink_cnt = q.blink_cnt + 32'h1;
    end

    // Port timers, one second resolution
    if (sec_tick) begin
      for (int i = 0; i < NP; i++) begin
        if (q.rst_act[i]) begin
          if (q.rst_rem[i] <= 16'h0001) begin
            n.rst_act[i] = 1'b0;
            n.relay[i]   = 1'b1;
          end else begin
            n.rst_rem[i] = q.rst_rem[i] - 16'h0001;
          end
        end
        if (q.bat_act[i]) begin
          if (q.bat_rem[i] <= 16'h0001) begin
            n.bat_act[i] = 1'b0;
            n.relay[i]   = q.bat_second[i];
          end else begin
            n.bat_rem[i] = q.bat_rem[i] - 16'h0001;
          end
        end
      end
    end

    // Mode stepping
    if (btn.sel_press) begin
      n.hold_cnt  = '0;
      n.hold_done = 1'b0;
      case (q.mode)
        panel_pkg::MODE_IDLE: begin
          n.sel = '0;
          if (!q.skip_on) begin
            n.mode = panel_pkg::MODE_ALL_ON;
          end else if (!q.skip_off) begin
            n.mode = panel_pkg::MODE_ALL_OFF;
          end else begin
            n.mode = panel_pkg::MODE_SINGLE;
          end
        end
        panel_pkg::MODE_ALL_ON: begin
          n.sel  = '0;
          n.mode = q.skip_off ? panel_pkg::MODE_SINGLE
                              : panel_pkg::MODE_ALL_OFF;
        end
        panel_pkg::MODE_ALL_OFF: begin
          n.sel  = '0;
          n.mode = panel_pkg::MODE_SINGLE;
        end
        panel_pkg::MODE_SINGLE: begin
          if (q.sel == LAST_SEL) begin
            n.mode = panel_pkg::MODE_IDLE;
          end else begin
            n.sel = q.sel + 3'h1;
          end
        end
        default: begin
          n.mode = panel_pkg::MODE_IDLE;
        end
      endcase
    end else if (!btn.ok_held) begin
      // Release before the target leaves everything as it was
      n.hold_cnt  = '0;
      n.hold_done = 1'b0;
    end else if (!q.hold_done && q.mode != panel_pkg::MODE_IDLE) begin
      if (q.hold_cnt == hold_target - 32'h1) begin
        n.hold_done = 1'b1;
        case (q.mode)
          panel_pkg::MODE_ALL_ON: begin
            n.relay   = '1;
            n.rst_act = '0;
            n.bat_act = '0;
          end
          panel_pkg::MODE_ALL_OFF: begin
            n.relay   = '0;
            n.rst_act = '0;
            n.bat_act = '0;
          end
          default: begin
            n.relay[q.sel]   = ~q.relay[q.sel];
            n.rst_act[q.sel] = 1'b0;
            n.bat_act[q.sel] = 1'b0;
          end
        endcase
      end else begin
        n.hold_cnt = q.hold_cnt + 32'h1;
      end
    end

    // APB decode and read data
    if (paddr == panel_pkg::CTRL_OFS) begin
      n.prdata = 32'({q.boot, q.ip_ok, q.link_up, q.skip_off, q.skip_on});
    end else if (paddr == panel_pkg::PORT_ON_OFS ||
                 paddr == panel_pkg::PORT_OFF_OFS) begin
      n.prdata = 32'(q.relay);
    end else if (paddr == panel_pkg::RESET_CMD_OFS) begin
      n.prdata = 32'(q.rst_act);
    end else if (paddr == panel_pkg::RESET_DUR_OFS) begin
      n.prdata = 32'(q.rst_dur);
    end else if (paddr == panel_pkg::BATCH_CMD_OFS) begin
      n.prdata = 32'(q.bat_act);
    end else if (paddr == panel_pkg::BATCH_TIME_OFS) begin
      n.prdata = 32'(q.bat_time);
    end else if (paddr == panel_pkg::STATUS_OFS) begin
      n.prdata = (32'(q.mode) << panel_pkg::STAT_MODE_LSB) | 32'(q.sel);
    end else begin
      n.prdata = '0;
      hit      = 1'b0;
    end
    if (!setup) begin
      n.prdata = q.prdata;
    end
    n.pready  = setup;
    n.pslverr = setup & ~hit;

    // Register writes, last so software wins over panel and timers
    if (wr) begin
      if (paddr == panel_pkg::CTRL_OFS) begin
        n.skip_on  = pwdata[panel_pkg::SKIP_ON_BIT];
        n.skip_off = pwdata[panel_pkg::SKIP_OFF_BIT];
        n.link_up  = pwdata[panel_pkg::LINK_BIT];
        n.ip_ok    = pwdata[panel_pkg::IP_OK_BIT];
        // Bootloader flag touches indicators only
        n.boot     = pwdata[panel_pkg::BOOT_BIT];
        if (pwdata[panel_pkg::RESTART_BIT]) begin
          // Restart clears the panel, never the relays
          n.mode      = panel_pkg::MODE_IDLE;
          n.sel       = '0;
          n.hold_cnt  = '0;
          n.hold_done = 1'b1;
        end
      end else if (paddr == panel_pkg::PORT_ON_OFS) begin
        n.relay   = n.relay | wmask;
        n.rst_act = n.rst_act & ~wmask;
        n.bat_act = n.bat_act & ~wmask;
      end else if (paddr == panel_pkg::PORT_OFF_OFS) begin
        n.relay   = n.relay & ~wmask;
        n.rst_act = n.rst_act & ~wmask;
        n.bat_act = n.bat_act & ~wmask;
      end else if (paddr == panel_pkg::RESET_CMD_OFS) begin
        for (int i = 0; i < NP; i++) begin
          if (wmask[i] && n.relay[i]) begin
            n.relay[i]   = 1'b0;
            n.rst_act[i] = 1'b1;
            n.rst_rem[i] = at_least_one(q.rst_dur);
            n.bat_act[i] = 1'b0;
          end
        end
      end else if (paddr == panel_pkg::RESET_DUR_OFS) begin
        n.rst_dur = pwdata[TW-1:0];
      end else if (paddr == panel_pkg::BATCH_CMD_OFS) begin
        for (int i = 0; i < NP; i++) begin
          if (wmask[i]) begin
            n.relay[i]      = pwdata[panel_pkg::BATCH_FIRST_BIT];
            n.bat_second[i] = pwdata[panel_pkg::BATCH_SECOND_BIT];
            n.bat_act[i]    = 1'b1;
            n.bat_rem[i]    = at_least_one(q.bat_time);
            n.rst_act[i]    = 1'b0;
          end
        end
      end else if (paddr == panel_pkg::BATCH_TIME_OFS) begin
        n.bat_time = pwdata[TW-1:0];
      end
    end

    // Port indicators
    for (int i = 0; i < NP; i++) begin
      n.led_on[i]  = n.relay[i];
      n.led_off[i] = ~n.relay[i];
      case (n.mode)
        panel_pkg::MODE_ALL_ON: begin
          n.led_on[i]  = q.blink;
          n.led_off[i] = 1'b0;
        end
        panel_pkg::MODE_ALL_OFF: begin
          n.led_on[i]  = 1'b0;
          n.led_off[i] = q.blink;
        end
        panel_pkg::MODE_SINGLE: begin
          if (n.sel == 3'(i)) begin
            n.led_on[i]  = n.relay[i] & q.blink;
            n.led_off[i] = ~n.relay[i] & q.blink;
          end
        end
        default: begin
        end
      endcase
    end

    // Status indicator, orange is red and green together
    base_red   = ~n.link_up | ~n.ip_ok;
    base_green = n.link_up;
    n.st_red   = base_red & (~n.boot | q.blink);
    n.st_green = base_green & (~n.boot | q.blink);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      q          <= '0;
      q.led_off  <= '1;
      q.st_red   <= 1'b1;
      q.rst_dur  <= panel_pkg::RESET_DUR_RST;
      q.bat_time <= panel_pkg::BATCH_TIME_RST;
    end else begin
      q <= n;
    end
  end

  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign relay        = q.relay;
  assign led_on       = q.led_on;
  assign led_off      = q.led_off;
  assign status_red   = q.st_red;
  assign status_green = q.st_green;

endmodule

/* src/panel_pkg.sv */
// Purpose: Shared constants and types for the front-panel port control.
// Assumes: 200 MHz mclk, APB register access with 32-bit data.
// Notes:   Times are kept in ms; cycle counts derive from the clock rate.
package panel_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 8;
  localparam int SEL_W     = 3;
  localparam int TMR_W     = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ     = 200000;
  localparam int ALL_HOLD_MS = 2500;
  localparam int ONE_HOLD_MS = 1000;
  localparam int DEBOUNCE_MS = 10;
  localparam int BLINK_MS    = 250;
  localparam int SECOND_MS   = 1000;

  localparam logic [31:0] ALL_HOLD_CYC = 32'(ALL_HOLD_MS * CLK_KHZ);
  localparam logic [31:0] ONE_HOLD_CYC = 32'(ONE_HOLD_MS * CLK_KHZ);
  localparam logic [31:0] DEBOUNCE_CYC = 32'(DEBOUNCE_MS * CLK_KHZ);
  localparam logic [31:0] BLINK_CYC    = 32'(BLINK_MS * CLK_KHZ);
  localparam logic [31:0] SECOND_CYC   = 32'(SECOND_MS * CLK_KHZ);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] PORT_ON_OFS    = 8'h04;
  localparam logic [7:0] PORT_OFF_OFS   = 8'h08;
  localparam logic [7:0] RESET_CMD_OFS  = 8'h0C;
  localparam logic [7:0] RESET_DUR_OFS  = 8'h10;
  localparam logic [7:0] BATCH_CMD_OFS  = 8'h14;
  localparam logic [7:0] BATCH_TIME_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS     = 8'h1C;

  // CTRL fields
  localparam int SKIP_ON_BIT  = 0;
  localparam int SKIP_OFF_BIT = 1;
  localparam int LINK_BIT     = 2;
  localparam int IP_OK_BIT    = 3;
  localparam int BOOT_BIT     = 4;
  localparam int RESTART_BIT  = 5;

  // BATCH_CMD fields, port mask in the low bits
  localparam int BATCH_FIRST_BIT  = 8;
  localparam int BATCH_SECOND_BIT = 9;

  // STATUS fields
  localparam int STAT_MODE_LSB = 4;

  // Reset values
  localparam logic [TMR_W-1:0] RESET_DUR_RST  = 16'h000A;
  localparam logic [TMR_W-1:0] BATCH_TIME_RST = 16'h000A;

  // ----------------------------------------------------------------
  // Front-panel modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_ALL_ON,
    MODE_ALL_OFF,
    MODE_SINGLE
  } panel_mode_t;

endpackage
